// *** core/ctsr_top.sv ***
// transmit status vectors, send requests and error counters of the controller
`timescale 1ns/1ns

// What this block does
// - each transmit pending bit reads 1 while any enabled condition of its fifo holds.
// - pending bit is or of enabled flags, drops by itself, ignores writes.
// - bit 0 of both pending vectors stands for the priority send queue.
// - attempt vector is read only; software clears it in the fifo's own register.
// - writing 1 to send request of objects 31..1 set for transmit requests sending.
// - send request clears itself only after all queued messages were sent.
// - writing 0 to a send request bit never cancels a transmission.
// - send request writes to objects set for reception have no effect.
// - send request bit 0 belongs to the priority queue, sets and self clears.
// - bus off flag at bit 21 set while transmit error count exceeds 255.
// - bus off flag reads 1 in configuration mode and after power on.
// - transmit passive flag at bit 20 set while transmit count above 127.
// - receive passive flag at bit 19 set while receive count above 127.
// - transmit warning flag at bit 18 set while count is 96 to 127.
// - receive warning flag at bit 17 set while count is 96 to 127.
// - combined warning flag at bit 16 is or of both warning flags.
// - transmit count in bits 15..8, receive count in 7..0, read only, reset 0.
// - diag register holds data phase transmit and receive counters in upper half.
// - diag register holds nominal phase transmit and receive counters in lower half.
module ctsr_top
   import ctsr_pkg::*;
(
   input  wire  logic         CLOCK,
   input  wire  logic         NRST,
   input  wire  logic         CE,
   input  wire  logic [2:0]   REG_ADDR,
   input  wire  logic         REG_WR,
   input  wire  logic         REG_RD,
   input  wire  logic [3:0]   REG_BE,
   input  wire  logic [31:0]  REG_WDATA,
   output var   logic [31:0]  REG_RDATA,
   output var   logic         REG_RVALID,
   output var   logic         REG_ERR,
   input  wire  logic [127:0] FIFO_FLAGS,
   input  wire  logic [127:0] FIFO_IRQ_EN,
   input  wire  logic [31:0]  FIFO_ATTEMPT_FLAG,
   input  wire  logic [31:0]  ATTEMPT_IRQ_EN,
   input  wire  logic [31:1]  TX_OBJECT_SELECT,
   input  wire  logic [31:0]  OBJECT_SENT,
   input  wire  logic         CONFIG_MODE,
   input  wire  logic [8:0]   TX_ERROR_COUNT_IN,
   input  wire  logic [7:0]   RX_ERROR_COUNT_IN,
   input  wire  logic [3:0]   DIAG_ERR_EVENT,
   output var   logic [31:0]  SEND_REQUEST,
   output var   logic [31:0]  TX_FIFO_IRQ_PENDING,
   output var   logic [31:0]  TX_ATTEMPT_IRQ_PENDING,
   output var   logic         BUS_OFF,
   output var   logic         ANY_WARNING
);

   // ==================================================================
   // helpers

   // expands byte enables into a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      logic [31:0] m;
      m = ZERO_WORD;
      for (int k = 0; k < 4; k++) begin
         m[k*BYTE_BITS +: BYTE_BITS] = {BYTE_BITS{be[k]}};
      end
      return m;
   endfunction

   // counters stop at full scale instead of wrapping to zero
   function automatic logic [7:0] sat_inc(input logic [7:0] v);
      if (v == COUNT_SATURATE) begin
         return v;
      end
      return v + 8'h01;
   endfunction

   // a register index this block answers to
   function automatic logic is_mapped(input logic [2:0] idx);
      return idx <= IDX_PHASE_ERROR_DIAG_COUNTERS;
   endfunction

   // ==================================================================
   // pending vector reduction

   ctsr_flags_if fl_if ();

   assign fl_if.flags   = FIFO_FLAGS;
   assign fl_if.enables = FIFO_IRQ_EN;

   ctsr_pend_or u_pend_or (
      .fl (fl_if.calc)
   );

   logic [31:0] tx_fifo_irq_pending_vector;
   logic [31:0] tx_attempt_irq_pending_vector;
   logic [31:0] next_tx_fifo_irq_pending_vector;
   logic [31:0] next_tx_attempt_irq_pending_vector;

   always_comb begin
      next_tx_fifo_irq_pending_vector    = fl_if.pending;
      next_tx_attempt_irq_pending_vector = FIFO_ATTEMPT_FLAG & ATTEMPT_IRQ_EN;
      if (!CE) begin
         next_tx_fifo_irq_pending_vector    = tx_fifo_irq_pending_vector;
         next_tx_attempt_irq_pending_vector = tx_attempt_irq_pending_vector;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         tx_fifo_irq_pending_vector    <= ZERO_WORD;
         tx_attempt_irq_pending_vector <= ZERO_WORD;
      end else begin
         tx_fifo_irq_pending_vector    <= next_tx_fifo_irq_pending_vector;
         tx_attempt_irq_pending_vector <= next_tx_attempt_irq_pending_vector;
      end
   end

   // ==================================================================
   // register write decode

   logic        wr_ok;
   logic [31:0] wr_bits;

   assign wr_ok   = CE && REG_WR && is_mapped(REG_ADDR);
   assign wr_bits = REG_WDATA & lane_mask(REG_BE);

   // ==================================================================
   // send requests

   logic [31:0] send_request_vector;
   logic [31:0] next_send_request_vector;
   logic [31:0] tx_capable;
   logic [31:0] sw_set;

   // the priority send queue always transmits
   assign tx_capable = {TX_OBJECT_SELECT, 1'b1};

   always_comb begin
      sw_set = ZERO_WORD;
      if (wr_ok && REG_ADDR == IDX_SEND_REQUEST_VECTOR) begin
         sw_set = wr_bits & tx_capable;
      end
      // zeros never clear
      // a set in the same cycle as completion wins, so a new request is kept
      next_send_request_vector = (send_request_vector & ~OBJECT_SENT) | sw_set;
      if (!CE) begin
         next_send_request_vector = send_request_vector;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         send_request_vector <= ZERO_WORD;
      end else begin
         send_request_vector <= next_send_request_vector;
      end
   end

   // ==================================================================
   // error counts and fault confinement state

   logic [31:0] error_count_and_state;
   logic [31:0] next_error_count_and_state;
   logic        tx_warn;
   logic        rx_warn;
   logic [8:0]  rx_wide;

   assign rx_wide = {1'b0, RX_ERROR_COUNT_IN};

   always_comb begin
      next_error_count_and_state = ZERO_WORD;
      tx_warn = TX_ERROR_COUNT_IN > WARNING_ABOVE && TX_ERROR_COUNT_IN < WARNING_BELOW;
      rx_warn = rx_wide > WARNING_ABOVE && rx_wide < WARNING_BELOW;
      next_error_count_and_state[BUS_OFF_BIT] =
         (TX_ERROR_COUNT_IN > BUS_OFF_ABOVE) || CONFIG_MODE;
      next_error_count_and_state[TX_PASSIVE_BIT] = TX_ERROR_COUNT_IN > PASSIVE_ABOVE;
      next_error_count_and_state[RX_PASSIVE_BIT] = rx_wide > PASSIVE_ABOVE;
      next_error_count_and_state[TX_WARNING_BIT] = tx_warn;
      next_error_count_and_state[RX_WARNING_BIT] = rx_warn;
      next_error_count_and_state[ANY_WARNING_BIT] = tx_warn || rx_warn;
      // counts mirrored
      // beyond 255 the 8-bit field pins at full scale rather than wrapping
      if (TX_ERROR_COUNT_IN > BUS_OFF_ABOVE) begin
         next_error_count_and_state[TX_COUNT_LSB +: BYTE_BITS] = COUNT_SATURATE;
      end else begin
         next_error_count_and_state[TX_COUNT_LSB +: BYTE_BITS] =
            TX_ERROR_COUNT_IN[BYTE_BITS-1:0];
      end
      next_error_count_and_state[RX_COUNT_LSB +: BYTE_BITS] = RX_ERROR_COUNT_IN;
      if (!CE) begin
         next_error_count_and_state = error_count_and_state;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         error_count_and_state <= ERROR_STATE_RESET;
      end else begin
         error_count_and_state <= next_error_count_and_state;
      end
   end

   // ==================================================================
   // phase error diagnostic counters, one byte lane each

   logic [31:0] phase_error_diag_counters;
   logic [31:0] next_phase_error_diag_counters;
   logic        diag_wr;

   assign diag_wr = wr_ok && REG_ADDR == IDX_PHASE_ERROR_DIAG_COUNTERS;

   genvar k;
   generate
      for (k = 0; k < NUM_DIAG_COUNT; k++) begin : g_diag
         always_comb begin
            // count or overwrite
            // a software write wins over an error in the same cycle
            next_phase_error_diag_counters[k*BYTE_BITS +: BYTE_BITS] =
               phase_error_diag_counters[k*BYTE_BITS +: BYTE_BITS];
            if (CE) begin
               if (diag_wr && REG_BE[k]) begin
                  next_phase_error_diag_counters[k*BYTE_BITS +: BYTE_BITS] =
                     REG_WDATA[k*BYTE_BITS +: BYTE_BITS];
               end else if (DIAG_ERR_EVENT[k]) begin
                  next_phase_error_diag_counters[k*BYTE_BITS +: BYTE_BITS] =
                     sat_inc(phase_error_diag_counters[k*BYTE_BITS +: BYTE_BITS]);
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         phase_error_diag_counters <= ZERO_WORD;
      end else begin
         phase_error_diag_counters <= next_phase_error_diag_counters;
      end
   end

   // ==================================================================
   // read path, answer one cycle after the request

   logic [31:0] next_rdata;
   logic        next_rvalid;
   logic        next_err;

   always_comb begin
      next_rdata  = ZERO_WORD;
      next_rvalid = 1'b0;
      next_err    = 1'b0;
      if (CE && (REG_RD || REG_WR)) begin
         next_err = !is_mapped(REG_ADDR);
      end
      if (CE && REG_RD) begin
         next_rvalid = 1'b1;
         case (REG_ADDR)
            IDX_TX_FIFO_IRQ_PENDING_VECTOR:    next_rdata = tx_fifo_irq_pending_vector;
            IDX_TX_ATTEMPT_IRQ_PENDING_VECTOR: next_rdata = tx_attempt_irq_pending_vector;
            IDX_SEND_REQUEST_VECTOR:           next_rdata = send_request_vector;
            IDX_ERROR_COUNT_AND_STATE:         next_rdata = error_count_and_state;
            IDX_PHASE_ERROR_DIAG_COUNTERS:     next_rdata = phase_error_diag_counters;
            default:                           next_rdata = ZERO_WORD;
         endcase
      end
      if (!CE) begin
         next_rdata  = REG_RDATA;
         next_rvalid = REG_RVALID;
         next_err    = REG_ERR;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         REG_RDATA  <= ZERO_WORD;
         REG_RVALID <= 1'b0;
         REG_ERR    <= 1'b0;
      end else begin
         REG_RDATA  <= next_rdata;
         REG_RVALID <= next_rvalid;
         REG_ERR    <= next_err;
      end
   end

   // ==================================================================
   // state outputs, each the flop of its register or a copy of it

   logic next_bus_off;
   logic next_any_warning;

   always_comb begin
      next_bus_off     = next_error_count_and_state[BUS_OFF_BIT];
      next_any_warning = next_error_count_and_state[ANY_WARNING_BIT];
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         BUS_OFF     <= ERROR_STATE_RESET[BUS_OFF_BIT];
         ANY_WARNING <= 1'b0;
      end else begin
         BUS_OFF     <= next_bus_off;
         ANY_WARNING <= next_any_warning;
      end
   end

   always_comb begin
      SEND_REQUEST           = send_request_vector;
      TX_FIFO_IRQ_PENDING    = tx_fifo_irq_pending_vector;
      TX_ATTEMPT_IRQ_PENDING = tx_attempt_irq_pending_vector;
   end

endmodule

// *** core/ctsr_pkg.sv ***
// constants shared by the transmit status and error counter block
package ctsr_pkg;

   // ==================================================================
   // register indices (word address = index on the register port)
   localparam logic [2:0] IDX_TX_FIFO_IRQ_PENDING_VECTOR    = 3'h0;
   localparam logic [2:0] IDX_TX_ATTEMPT_IRQ_PENDING_VECTOR = 3'h1;
   localparam logic [2:0] IDX_SEND_REQUEST_VECTOR           = 3'h2;
   localparam logic [2:0] IDX_ERROR_COUNT_AND_STATE         = 3'h3;
   localparam logic [2:0] IDX_PHASE_ERROR_DIAG_COUNTERS     = 3'h4;

   // ==================================================================
   // sizes
   localparam int NUM_OBJECTS     = 32;
   localparam int FLAGS_PER_FIFO  = 4;
   localparam int NUM_DIAG_COUNT  = 4;
   localparam int BYTE_BITS       = 8;

   // ==================================================================
   // error count and state field positions
   localparam int BUS_OFF_BIT     = 21;
   localparam int TX_PASSIVE_BIT  = 20;
   localparam int RX_PASSIVE_BIT  = 19;
   localparam int TX_WARNING_BIT  = 18;
   localparam int RX_WARNING_BIT  = 17;
   localparam int ANY_WARNING_BIT = 16;
   localparam int TX_COUNT_LSB    = 8;
   localparam int RX_COUNT_LSB    = 0;

   // ==================================================================
   // diag counter lanes: lane k holds bits 8k+7..8k
   localparam int DIAG_NOM_RX = 0;
   localparam int DIAG_NOM_TX = 1;
   localparam int DIAG_DAT_RX = 2;
   localparam int DIAG_DAT_TX = 3;

   // ==================================================================
   // thresholds of the fault confinement states
   localparam logic [8:0] BUS_OFF_ABOVE   = 9'h0ff;
   localparam logic [8:0] PASSIVE_ABOVE   = 9'h07f;
   localparam logic [8:0] WARNING_ABOVE   = 9'h05f;
   localparam logic [8:0] WARNING_BELOW   = 9'h080;
   localparam logic [7:0] COUNT_SATURATE  = 8'hff;

   // ==================================================================
   // reset values
   localparam logic [31:0] ERROR_STATE_RESET = 32'h0020_0000;
   localparam logic [31:0] ZERO_WORD         = 32'h0000_0000;

endpackage

// *** core/ctsr_flags_if.sv ***
// carrier of per-fifo flags and enables into the pending vector reducer
`timescale 1ns/1ns
interface ctsr_flags_if;
   logic [31:0][3:0] flags;
   logic [31:0][3:0] enables;
   logic [31:0]      pending;
   modport src  (output flags, output enables, input pending);
   modport calc (input flags, input enables, output pending);
endinterface

// *** core/ctsr_pend_or.sv ***
// per-fifo or-reduction of enabled interrupt flags
`timescale 1ns/1ns
module ctsr_pend_or
   import ctsr_pkg::*;
(
   ctsr_flags_if.calc fl
);
   // ==================================================================
   // one pending bit per fifo, bit 0 is the priority send queue
   genvar i;
   generate
      for (i = 0; i < NUM_OBJECTS; i++) begin : g_fifo
         assign fl.pending[i] = |(fl.flags[i] & fl.enables[i]);
      end
   endgenerate
endmodule

// *** bench/ctsr_props.sv ***
// concurrent checks on the ports of the transmit status block
`timescale 1ns/1ns
module ctsr_props
   import ctsr_pkg::*;
(
   input wire logic         CLOCK,
   input wire logic         NRST,
   input wire logic         CE,
   input wire logic [2:0]   REG_ADDR,
   input wire logic         REG_WR,
   input wire logic         REG_RD,
   input wire logic [3:0]   REG_BE,
   input wire logic [31:0]  REG_WDATA,
   input wire logic         REG_ERR,
   input wire logic [127:0] FIFO_FLAGS,
   input wire logic [127:0] FIFO_IRQ_EN,
   input wire logic [31:0]  FIFO_ATTEMPT_FLAG,
   input wire logic [31:0]  ATTEMPT_IRQ_EN,
   input wire logic [31:1]  TX_OBJECT_SELECT,
   input wire logic [31:0]  OBJECT_SENT,
   input wire logic         CONFIG_MODE,
   input wire logic [8:0]   TX_ERROR_COUNT_IN,
   input wire logic [7:0]   RX_ERROR_COUNT_IN,
   input wire logic [31:0]  SEND_REQUEST,
   input wire logic [31:0]  TX_FIFO_IRQ_PENDING,
   input wire logic [31:0]  TX_ATTEMPT_IRQ_PENDING,
   input wire logic         BUS_OFF,
   input wire logic         ANY_WARNING
);
   // ====
   // helper logic
   logic [31:0] por;
   logic        warn;
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         por[i] = |(FIFO_FLAGS[4*i+:4] & FIFO_IRQ_EN[4*i+:4]);
      end
      warn = (TX_ERROR_COUNT_IN > 9'h05f && TX_ERROR_COUNT_IN < 9'h080)
         || (RX_ERROR_COUNT_IN > 8'h5f && RX_ERROR_COUNT_IN < 8'h80);
   end
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!NRST);
   // ====
   // sequences
   // the previous edge was out of reset and enabled, so every mirror loaded
   sequence s_live;
      $past(NRST) && $past(CE);
   endsequence
   sequence s_set0;
      CE && REG_WR && REG_ADDR == 3'h2 && REG_BE[0] && REG_WDATA[0];
   endsequence
   // ====
   // assertions
   a_pend_or_flags: assert property (s_live |-> TX_FIFO_IRQ_PENDING == $past(por))
      else $error("fifo pending vector wrong");
   a_attempt_and_en: assert property (s_live |->
      TX_ATTEMPT_IRQ_PENDING == $past(FIFO_ATTEMPT_FLAG & ATTEMPT_IRQ_EN))
      else $error("attempt vector wrong");
   a_bus_off_flag: assert property (s_live |->
      BUS_OFF == $past(TX_ERROR_COUNT_IN > 9'h0ff || CONFIG_MODE))
      else $error("bus off flag wrong");
   a_any_warning: assert property (s_live |-> ANY_WARNING == $past(warn))
      else $error("warning flag wrong");
   a_err_unmapped: assert property (s_live |->
      REG_ERR == $past(REG_ADDR > 3'h4 && (REG_RD || REG_WR)))
      else $error("unmapped error pulse wrong");
   a_queue_set: assert property (s_set0 |=> SEND_REQUEST[0])
      else $error("queue request not set");
   a_req_no_abort: assert property (SEND_REQUEST[0] && !OBJECT_SENT[0] |=> SEND_REQUEST[0])
      else $error("queue request dropped early");
   a_req_clear: assert property ($past(NRST) |->
      ($past(SEND_REQUEST & ~OBJECT_SENT) & ~SEND_REQUEST) == 32'h0)
      else $error("request cleared without sent");
   a_req_rise: assert property ($past(NRST) && (SEND_REQUEST & ~$past(SEND_REQUEST)) != 32'h0
      |-> $past(CE && REG_WR && REG_ADDR == 3'h2))
      else $error("request set without write");
   a_rx_ignore: assert property ($past(NRST) |->
      (SEND_REQUEST & ~$past(SEND_REQUEST) & ~{$past(TX_OBJECT_SELECT), 1'b1}) == 32'h0)
      else $error("receive object request set");
endmodule

// *** bench/ctsr_far_model.sv ***
// far side model: sends queued objects and reports them sent
`timescale 1ns/1ns
module ctsr_far_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        hold,
   input  wire logic [31:0] req,
   output var  logic [31:0] sent
);
   logic [1:0]  cnt;
   logic [1:0]  next_cnt;
   logic [31:0] next_sent;
   // send then report
   // one object every fourth cycle, lowest first; hold stalls the bus
   always_comb begin
      next_cnt = (req != 32'h0 && !hold) ? cnt + 2'h1 : 2'h0;
      next_sent = (cnt == 2'h3) ? (req & (~req + 32'h1)) : 32'h0;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 2'h0;
         sent <= 32'h0;
      end else begin
         cnt <= next_cnt;
         sent <= next_sent;
      end
   end
endmodule

// *** bench/ctsr_top_test.sv ***
// self-checking bench of the transmit status and error counter block
`timescale 1ns/1ns
module ctsr_top_test
   import ctsr_pkg::*;
;
   logic         CLOCK;
   logic         NRST;
   logic         CE;
   logic         REG_WR;
   logic         REG_RD;
   logic         CONFIG_MODE;
   logic         hold;
   logic [2:0]   REG_ADDR;
   logic [3:0]   REG_BE;
   logic [3:0]   DIAG_ERR_EVENT;
   logic [31:0]  REG_WDATA;
   logic [31:0]  REG_RDATA;
   logic         REG_RVALID;
   logic         REG_ERR;
   logic [127:0] FIFO_FLAGS;
   logic [127:0] FIFO_IRQ_EN;
   logic [31:0]  FIFO_ATTEMPT_FLAG;
   logic [31:0]  ATTEMPT_IRQ_EN;
   logic [31:1]  TX_OBJECT_SELECT;
   logic [31:0]  OBJECT_SENT;
   logic [8:0]   TX_ERROR_COUNT_IN;
   logic [7:0]   RX_ERROR_COUNT_IN;
   logic [31:0]  SEND_REQUEST;
   logic [31:0]  TX_FIFO_IRQ_PENDING;
   logic [31:0]  TX_ATTEMPT_IRQ_PENDING;
   logic         BUS_OFF;
   logic         ANY_WARNING;
   logic [31:0]  rnd;
   logic [31:0]  ew;
   logic [319:0] big;
   int           fails;
   int           check_count;
   localparam logic [8:0] CORNER [8] = '{9'h05f, 9'h060, 9'h07f, 9'h080,
                                         9'h0ff, 9'h100, 9'h000, 9'h1ff};
   ctsr_top dut_u (.CLOCK(CLOCK), .NRST(NRST), .CE(CE), .REG_ADDR(REG_ADDR),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_BE(REG_BE), .REG_WDATA(REG_WDATA),
      .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .REG_ERR(REG_ERR),
      .FIFO_FLAGS(FIFO_FLAGS), .FIFO_IRQ_EN(FIFO_IRQ_EN),
      .FIFO_ATTEMPT_FLAG(FIFO_ATTEMPT_FLAG), .ATTEMPT_IRQ_EN(ATTEMPT_IRQ_EN),
      .TX_OBJECT_SELECT(TX_OBJECT_SELECT), .OBJECT_SENT(OBJECT_SENT),
      .CONFIG_MODE(CONFIG_MODE), .TX_ERROR_COUNT_IN(TX_ERROR_COUNT_IN),
      .RX_ERROR_COUNT_IN(RX_ERROR_COUNT_IN), .DIAG_ERR_EVENT(DIAG_ERR_EVENT),
      .SEND_REQUEST(SEND_REQUEST), .TX_FIFO_IRQ_PENDING(TX_FIFO_IRQ_PENDING),
      .TX_ATTEMPT_IRQ_PENDING(TX_ATTEMPT_IRQ_PENDING), .BUS_OFF(BUS_OFF),
      .ANY_WARNING(ANY_WARNING));
   ctsr_far_model far_u (.clk(CLOCK), .rst_n(NRST), .hold(hold), .req(SEND_REQUEST),
      .sent(OBJECT_SENT));
   // ====
   // expectations
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] pend(input logic [127:0] f, input logic [127:0] e);
      for (int i = 0; i < 32; i++) pend[i] = |(f[4*i+:4] & e[4*i+:4]);
   endfunction
   function automatic logic [31:0] err_word(input logic [8:0] t, input logic [7:0] r,
                                             input logic c);
      logic tw;
      logic rw;
      tw = t > 9'h05f && t < 9'h080;
      rw = r > 8'h5f && r < 8'h80;
      return {10'h0, c || t > 9'h0ff, t > 9'h07f, r > 8'h7f, tw, rw, tw || rw,
              (t > 9'h0ff) ? 8'hff : t[7:0], r};
   endfunction
   function automatic logic [7:0] sat(input logic [7:0] v, input logic [7:0] n);
      return ({1'b0, v} + {1'b0, n} > 9'h0ff) ? 8'hff : v + n;
   endfunction
   // ====
   // bus tasks
   task automatic tick();
      @(posedge CLOCK);
      #10;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [3:0] be, input logic [31:0] d);
      {REG_ADDR, REG_BE, REG_WDATA, REG_WR} = {a, be, d, 1'b1};
      tick();
      REG_WR = 1'b0;
      tick();
   endtask
   task automatic rd(input logic [2:0] a, input logic [31:0] exp, input string what);
      {REG_ADDR, REG_RD} = {a, 1'b1};
      tick();
      REG_RD = 1'b0;
      chk(what, REG_RDATA, exp);
      chk("read valid", {31'h0, REG_RVALID}, 32'h1);
      chk("read error", {31'h0, REG_ERR}, {31'h0, a > 3'h4});
      tick();
      // valid stands for one cycle only
      chk("read valid end", {31'h0, REG_RVALID}, 32'h0);
   endtask
   task automatic final_report();
      if (fails == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      CLOCK = 1'b0;
      forever #50 CLOCK = ~CLOCK;
   end
   // watchdog sized well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge CLOCK);
      fails++;
      final_report();
   end
   initial begin
      {fails, check_count, rnd} = {32'h0, 32'h0, 32'h0000_000f};
      {NRST, CE, REG_WR, REG_RD, CONFIG_MODE, hold} = 6'b010011;
      {REG_ADDR, REG_BE, DIAG_ERR_EVENT, REG_WDATA, big} = '0;
      {FIFO_FLAGS, FIFO_IRQ_EN, FIFO_ATTEMPT_FLAG, ATTEMPT_IRQ_EN} = '0;
      {TX_OBJECT_SELECT, TX_ERROR_COUNT_IN, RX_ERROR_COUNT_IN} = '0;
      repeat (8) @(posedge CLOCK);
      #10;
      chk("bus off in reset", {31'h0, BUS_OFF}, 32'h1);
      NRST = 1'b1;
      tick();
      tick();
      for (int a = 0; a < 8; a++) rd(3'(a), (a == 3) ? ERROR_STATE_RESET : ZERO_WORD, "reset");
      CONFIG_MODE = 1'b0;
      for (int i = 0; i < 24; i++) begin
         for (int k = 0; k < 10; k++) begin
            rnd = lfsr(rnd);
            big[32*k+:32] = rnd;
         end
         // attempt flags change only from the fifo side
         {FIFO_FLAGS, FIFO_IRQ_EN, FIFO_ATTEMPT_FLAG, ATTEMPT_IRQ_EN} = big;
         TX_ERROR_COUNT_IN = (i < 8) ? CORNER[i] : rnd[8:0];
         RX_ERROR_COUNT_IN = (i < 8) ? CORNER[7-i][7:0] : rnd[15:8];
         ew = err_word(TX_ERROR_COUNT_IN, RX_ERROR_COUNT_IN, 1'b0);
         wr(IDX_TX_FIFO_IRQ_PENDING_VECTOR, 4'hf, rnd);
         wr(IDX_TX_ATTEMPT_IRQ_PENDING_VECTOR, 4'hf, rnd);
         wr(IDX_ERROR_COUNT_AND_STATE, 4'hf, ~rnd);
         rd(IDX_TX_FIFO_IRQ_PENDING_VECTOR, pend(FIFO_FLAGS, FIFO_IRQ_EN), "pend");
         rd(IDX_TX_ATTEMPT_IRQ_PENDING_VECTOR, big[31:0] & big[63:32], "attempt");
         rd(IDX_ERROR_COUNT_AND_STATE, ew, "error word");
         chk("bus off", {31'h0, BUS_OFF}, {31'h0, ew[21]});
         chk("any warning", {31'h0, ANY_WARNING}, {31'h0, ew[16]});
      end
      TX_OBJECT_SELECT = rnd[31:1];
      CE = 1'b0;
      wr(IDX_SEND_REQUEST_VECTOR, 4'hf, 32'hffff_ffff);
      CE = 1'b1;
      rd(IDX_SEND_REQUEST_VECTOR, ZERO_WORD, "frozen request");
      wr(IDX_SEND_REQUEST_VECTOR, 4'h5, 32'hffff_ffff);
      rd(IDX_SEND_REQUEST_VECTOR, {TX_OBJECT_SELECT, 1'b1} & 32'h00ff_00ff, "lanes");
      wr(IDX_SEND_REQUEST_VECTOR, 4'hf, 32'hffff_ffff);
      wr(IDX_SEND_REQUEST_VECTOR, 4'hf, ZERO_WORD);
      rd(IDX_SEND_REQUEST_VECTOR, {TX_OBJECT_SELECT, 1'b1}, "no abort");
      hold = 1'b0;
      for (int n = 0; n < 400 && SEND_REQUEST !== ZERO_WORD; n++) tick();
      chk("self clear", SEND_REQUEST, ZERO_WORD);
      rnd = lfsr(rnd);
      wr(IDX_PHASE_ERROR_DIAG_COUNTERS, 4'hf, rnd);
      rd(IDX_PHASE_ERROR_DIAG_COUNTERS, rnd, "diag write");
      wr(IDX_PHASE_ERROR_DIAG_COUNTERS, 4'h2, 32'h0000_fe00);
      ew = {rnd[31:16], 8'hfe, rnd[7:0]};
      // lane k gets k+1 events, so a swapped lane shows up
      for (int k = 0; k < 4; k++) begin
         repeat (k + 1) begin
            DIAG_ERR_EVENT = 4'(1 << k);
            tick();
            DIAG_ERR_EVENT = 4'h0;
            tick();
         end
         ew[8*k+:8] = sat(ew[8*k+:8], 8'(k + 1));
      end
      rd(IDX_PHASE_ERROR_DIAG_COUNTERS, ew, "diag count");
      CONFIG_MODE = 1'b1;
      NRST = 1'b0;
      tick();
      NRST = 1'b1;
      tick();
      rd(IDX_PHASE_ERROR_DIAG_COUNTERS, ZERO_WORD, "diag reset");
      ew = err_word(TX_ERROR_COUNT_IN, RX_ERROR_COUNT_IN, 1'b1);
      rd(IDX_ERROR_COUNT_AND_STATE, ew, "config word");
      final_report();
   end
endmodule
bind ctsr_top ctsr_props props_u (.CLOCK(CLOCK), .NRST(NRST), .CE(CE),
   .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_BE(REG_BE),
   .REG_WDATA(REG_WDATA), .REG_ERR(REG_ERR), .FIFO_FLAGS(FIFO_FLAGS),
   .FIFO_IRQ_EN(FIFO_IRQ_EN), .FIFO_ATTEMPT_FLAG(FIFO_ATTEMPT_FLAG),
   .ATTEMPT_IRQ_EN(ATTEMPT_IRQ_EN), .TX_OBJECT_SELECT(TX_OBJECT_SELECT),
   .OBJECT_SENT(OBJECT_SENT), .CONFIG_MODE(CONFIG_MODE),
   .TX_ERROR_COUNT_IN(TX_ERROR_COUNT_IN), .RX_ERROR_COUNT_IN(RX_ERROR_COUNT_IN),
   .SEND_REQUEST(SEND_REQUEST), .TX_FIFO_IRQ_PENDING(TX_FIFO_IRQ_PENDING),
   .TX_ATTEMPT_IRQ_PENDING(TX_ATTEMPT_IRQ_PENDING), .BUS_OFF(BUS_OFF),
   .ANY_WARNING(ANY_WARNING));
